// ### verif/oag_core_tb.sv
// self-checking bench for the oag core
// assumes the memory model answers on the far side
`timescale 1ns/1ps
`default_nettype none
module oag_core_tb;
    // ****************
    // stimulus and model
    // ****************
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    oag_pkg::oag_op_t op_code = oag_pkg::OAG_OP_NOP;
    logic ptr_sel = 1'b0;
    oag_pkg::oag_step_t ptr_step = oag_pkg::OAG_STEP_NONE;
    logic [7:0] op_byte = 8'h00;
    logic [2:0] bit_idx = 3'h0;
    logic op_ready, dmem_rd, dmem_wr, bit_flag;
    logic [14:0] pmem_addr, pc_out;
    logic [7:0] pmem_rdata, dmem_addr, dmem_wdata, dmem_rdata;
    logic [7:0] acc_out, ptr0_out, ptr1_out, stack_pointer_reg;
    logic [7:0] e_acc, e_p0, e_p1, sh [256];
    logic [14:0] e_pc;
    logic e_flag;
    int num_errors = 0;
    int total_checks = 0;
    oag_core i_oag_core (.clk_sys(clk_sys), .rst_n(rst_n),
        .op_valid(op_valid), .op_code(op_code), .ptr_sel(ptr_sel),
        .ptr_step(ptr_step), .op_byte(op_byte), .bit_idx(bit_idx),
        .op_ready(op_ready), .pmem_addr(pmem_addr),
        .pmem_rdata(pmem_rdata), .dmem_addr(dmem_addr),
        .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata),
        .dmem_rdata(dmem_rdata), .acc_out(acc_out), .ptr0_out(ptr0_out),
        .ptr1_out(ptr1_out), .stack_pointer_reg(stack_pointer_reg),
        .pc_out(pc_out), .bit_flag(bit_flag));
    oag_mem_model i_oag_mem_model (.clk_sys(clk_sys),
        .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
        .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
        .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] pm(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3C;
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [14:0] g, input logic [14:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic do_op(input oag_pkg::oag_op_t o, input logic s,
        input oag_pkg::oag_step_t st, input logic [7:0] b,
        input logic [2:0] i);
        logic [7:0] p, pn, t;
        int n;
        logic slow;
        p = s ? e_p1 : e_p0;
        pn = (st == oag_pkg::OAG_STEP_INC) ? p + 8'h01 :
            (st == oag_pkg::OAG_STEP_DEC) ? p - 8'h01 : p;
        slow = (o == oag_pkg::OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE) || (o >= oag_pkg::OAG_OP_BIT_SET);
        case (o)
            oag_pkg::OAG_OP_LD_DIR: e_acc = sh[b];
            oag_pkg::OAG_OP_LD_IND, oag_pkg::OAG_OP_X_IND: begin
                t = sh[p];
                if (o == oag_pkg::OAG_OP_X_IND) sh[p] = e_acc;
                e_acc = t;
                if (s) e_p1 = pn;
                else e_p0 = pn;
            end
            oag_pkg::OAG_OP_ST_DIR: sh[b] = e_acc;
            oag_pkg::OAG_OP_LD_IMM: e_acc = pm(e_pc);
            oag_pkg::OAG_OP_LD_PTR0_SHORT: e_p0 = {4'h0, b[3:0]};
            oag_pkg::OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE: e_acc = pm({e_pc[14:8], e_acc});
            oag_pkg::OAG_OP_BIT_SET: sh[b][i] = 1'b1;
            oag_pkg::OAG_OP_BIT_CLR: sh[b][i] = 1'b0;
            oag_pkg::OAG_OP_BIT_TEST: e_flag = sh[b][i];
            default: ;
        endcase
        e_pc = e_pc + 15'h0001;
        op_valid = 1'b1;
        op_code = o;
        ptr_sel = s;
        ptr_step = st;
        op_byte = b;
        bit_idx = i;
        @(posedge clk_sys);
        #1;
        op_valid = 1'b0;
        chk({14'h0000, op_ready}, {14'h0000, !slow});
        n = 0;
        while (op_ready !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 8) begin
            num_errors++;
            finish_test();
        end
        @(posedge clk_sys);
        #1;
        chk({7'h00, acc_out}, {7'h00, e_acc});
        chk({7'h00, ptr0_out}, {7'h00, e_p0});
        chk({7'h00, ptr1_out}, {7'h00, e_p1});
        chk({7'h00, stack_pointer_reg}, 15'h0000);
        chk(pc_out, e_pc);
        chk({14'h0000, bit_flag}, {14'h0000, e_flag});
    endtask
    initial begin
        for (int k = 0; k < 256; k++) sh[k] = 8'(k) ^ 8'hA5;
        {e_acc, e_p0, e_p1, e_pc, e_flag} = '0;
        void'($urandom(1087));
        repeat (12) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        // corners: nibble clear, pointer wrap both ways, set and test of bit 7 at data byte FE
        do_op(oag_pkg::OAG_OP_LD_PTR0_SHORT, 0, oag_pkg::OAG_STEP_NONE, 8'hF3, 0);
        do_op(oag_pkg::OAG_OP_LD_IND, 0, oag_pkg::OAG_STEP_DEC, 8'h00, 0);
        do_op(oag_pkg::OAG_OP_X_IND, 1, oag_pkg::OAG_STEP_DEC, 8'h00, 0);
        do_op(oag_pkg::OAG_OP_X_IND, 1, oag_pkg::OAG_STEP_INC, 8'h00, 0);
        do_op(oag_pkg::OAG_OP_BIT_SET, 0, oag_pkg::OAG_STEP_NONE, 8'hFE, 7);
        do_op(oag_pkg::OAG_OP_BIT_TEST, 0, oag_pkg::OAG_STEP_NONE, 8'hFE, 7);
        do_op(oag_pkg::OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE, 0, oag_pkg::OAG_STEP_NONE, 8'h00, 0);
        $display("corner test done");
        // random mix covers every operation kind
        for (int k = 0; k < 400; k++) begin
            do_op(oag_pkg::oag_op_t'($urandom_range(0, 10)), 1'($urandom),
                oag_pkg::oag_step_t'($urandom_range(0, 2)), 8'($urandom),
                3'($urandom));
        end
        $display("random test done");
        finish_test();
    end
endmodule
`default_nettype wire

// ### verif/oag_mem_model.sv
// behavioural program and data memories facing the oag core
// assumes one clock; a data read answers one cycle after its request
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model (
    input wire logic clk_sys,
    input wire logic [14:0] pmem_addr,
    output logic [7:0] pmem_rdata,
    input wire logic [7:0] dmem_addr,
    input wire logic dmem_rd,
    input wire logic dmem_wr,
    input wire logic [7:0] dmem_wdata,
    output var logic [7:0] dmem_rdata
);
    // ****************
    // memories
    // ****************
    logic [7:0] mem_q [256];
    initial begin
        for (int k = 0; k < 256; k++) begin
            mem_q[k] = 8'(k) ^ 8'hA5;
        end
        dmem_rdata = 8'h00;
    end
    // table contents are a fixed function of the address
    assign pmem_rdata = pmem_addr[7:0] ^ {1'b0, pmem_addr[14:8]} ^ 8'h3C;
    // an idle read port flips its last value, so stale data never matches
    always @(posedge clk_sys) begin
        dmem_rdata <= dmem_rd ? mem_q[dmem_addr] : ~dmem_rdata;
        if (dmem_wr) begin
            mem_q[dmem_addr] <= dmem_wdata;
        end
    end
endmodule
`default_nettype wire

// ### verilog/oag_core.sv
// operand address generation: data and program memory addressing
// assumes synchronous data memory: read valid the cycle after dmem_rd; program memory read is combinational
`include "oag_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module oag_core #(
    parameter int DW = `OAG_DW,
    parameter int PCW = `OAG_PCW
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire oag_pkg::oag_op_t op_code,
    input wire logic ptr_sel,
    input wire oag_pkg::oag_step_t ptr_step,
    input wire logic [DW-1:0] op_byte,
    input wire logic [2:0] bit_idx,
    output logic op_ready,
    output logic [PCW-1:0] pmem_addr,
    input wire logic [DW-1:0] pmem_rdata,
    output logic [DW-1:0] dmem_addr,
    output logic dmem_rd,
    output logic dmem_wr,
    output logic [DW-1:0] dmem_wdata,
    input wire logic [DW-1:0] dmem_rdata,
    output logic [DW-1:0] acc_out,
    output logic [DW-1:0] ptr0_out,
    output logic [DW-1:0] ptr1_out,
    output logic [DW-1:0] stack_pointer_reg,
    output logic [PCW-1:0] pc_out,
    output logic bit_flag
);
    // ********************************************************
    // state
    // ********************************************************
    oag_pkg::oag_state_t state_q;
    logic [DW-1:0] acc_q;
    logic [DW-1:0] ptr0_q;
    logic [DW-1:0] ptr1_q;
    logic [DW-1:0] sp_q;
    logic [PCW-1:0] pc_q;
    logic [DW-1:0] rmw_addr_q;
    logic [2:0] rmw_bit_q;
    logic rmw_set_q;
    logic rmw_test_q;
    logic xchg_q;
    logic bit_flag_q;
    logic [DW-1:0] sel_ptr;
    logic [DW-1:0] stepped_ptr;
    logic take;
    logic is_ind;
    logic [DW-1:0] pc_low_byte;
    logic [DW-1:0] pc_upper_byte;

    // decode used by the pointer update and the step checks
    function automatic logic uses_ptr(input oag_pkg::oag_op_t op);
        return op == oag_pkg::OAG_OP_LD_IND || op == oag_pkg::OAG_OP_X_IND;
    endfunction

    assign take = op_valid && op_ready;
    assign is_ind = uses_ptr(op_code);
    assign sel_ptr = ptr_sel ? ptr1_q : ptr0_q;
    assign pc_low_byte = pc_q[DW-1:0];
    assign pc_upper_byte = {1'b0, pc_q[PCW-1:DW]};
    // single-cycle ops accept every cycle; bit and table ops take two
    assign op_ready = (state_q == oag_pkg::OAG_ST_IDLE);

    oag_ptr_step #(
        .W(DW)
    ) u_step (
        .ptr_in(sel_ptr),
        .step(ptr_step),
        .ptr_out(stepped_ptr)
    );

    // ********************************************************
    // memory addressing
    // ********************************************************
    always_comb begin
        dmem_addr = op_byte;
        dmem_rd = 1'b0;
        dmem_wr = 1'b0;
        dmem_wdata = acc_q;
        pmem_addr = pc_q;
        if (state_q == oag_pkg::OAG_ST_RMW) begin
            dmem_addr = rmw_addr_q;
            dmem_wr = !rmw_test_q;
            dmem_wdata = dmem_rdata;
            dmem_wdata[rmw_bit_q] = rmw_set_q;
        end else if (state_q == oag_pkg::OAG_ST_TABLE) begin
            // accumulator stands in for the low pc byte
            pmem_addr = {pc_q[PCW-1:DW], acc_q};
        end else if (op_valid) begin
            case (op_code)
                oag_pkg::OAG_OP_LD_DIR: dmem_rd = 1'b1;
                oag_pkg::OAG_OP_ST_DIR: dmem_wr = 1'b1;
                oag_pkg::OAG_OP_LD_IND: begin
                    dmem_addr = sel_ptr;
                    dmem_rd = 1'b1;
                end
                oag_pkg::OAG_OP_X_IND: begin
                    dmem_addr = sel_ptr;
                    dmem_rd = 1'b1;
                    dmem_wr = 1'b1;
                end
                oag_pkg::OAG_OP_BIT_SET, oag_pkg::OAG_OP_BIT_CLR,
                oag_pkg::OAG_OP_BIT_TEST: dmem_rd = 1'b1;
                default: ;
            endcase
        end
    end

    // ********************************************************
    // sequencing
    // ********************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= oag_pkg::OAG_ST_IDLE;
        end else begin
            case (state_q)
                oag_pkg::OAG_ST_IDLE: begin
                    if (take && op_code == oag_pkg::OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE) begin
                        state_q <= oag_pkg::OAG_ST_TABLE;
                    end else if (take && (op_code == oag_pkg::OAG_OP_BIT_SET ||
                        op_code == oag_pkg::OAG_OP_BIT_CLR ||
                        op_code == oag_pkg::OAG_OP_BIT_TEST)) begin
                        state_q <= oag_pkg::OAG_ST_RMW;
                    end
                end
                default: state_q <= oag_pkg::OAG_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rmw_addr_q <= `OAG_PTR_RST;
            rmw_bit_q <= 3'h0;
            rmw_set_q <= 1'b0;
            rmw_test_q <= 1'b0;
            xchg_q <= 1'b0;
        end else begin
            xchg_q <= take && (op_code == oag_pkg::OAG_OP_LD_IND ||
                op_code == oag_pkg::OAG_OP_X_IND || op_code == oag_pkg::OAG_OP_LD_DIR);
            if (take) begin
                rmw_addr_q <= op_byte;
                rmw_bit_q <= bit_idx;
                rmw_set_q <= (op_code == oag_pkg::OAG_OP_BIT_SET);
                rmw_test_q <= (op_code == oag_pkg::OAG_OP_BIT_TEST);
            end
        end
    end

    // ********************************************************
    // pointers
    // ********************************************************
    // the step lands after the access uses the old value
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ptr0_q <= `OAG_PTR_RST;
            ptr1_q <= `OAG_PTR_RST;
            sp_q <= `OAG_PTR_RST;
        end else if (take && op_code == oag_pkg::OAG_OP_LD_PTR0_SHORT) begin
            ptr0_q <= {`OAG_HI_ZERO, op_byte[`OAG_NIB_W-1:0]};
        end else if (take && is_ind) begin
            if (ptr_sel) begin
                ptr1_q <= stepped_ptr;
            end else begin
                ptr0_q <= stepped_ptr;
            end
        end
    end

    // ********************************************************
    // accumulator, flag and program counter
    // ********************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_q <= `OAG_ACC_RST;
            bit_flag_q <= 1'b0;
        end else if (state_q == oag_pkg::OAG_ST_TABLE) begin
            acc_q <= pmem_rdata;
        end else if (state_q == oag_pkg::OAG_ST_RMW) begin
            if (rmw_test_q) begin
                bit_flag_q <= dmem_rdata[rmw_bit_q];
            end
        end else if (xchg_q) begin
            acc_q <= dmem_rdata;
        end else if (take && op_code == oag_pkg::OAG_OP_LD_IMM) begin
            acc_q <= pmem_rdata;
        end
    end

    // pc is never overwritten by the table access, so it comes back intact
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_q <= `OAG_PC_RST;
        end else if (state_q == oag_pkg::OAG_ST_TABLE) begin
            pc_q <= pc_q + `OAG_PC_STEP;
        end else if (take && op_code != oag_pkg::OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE) begin
            pc_q <= pc_q + `OAG_PC_STEP;
        end
    end

    assign acc_out = acc_q;
    assign ptr0_out = ptr0_q;
    assign ptr1_out = ptr1_q;
    assign stack_pointer_reg = sp_q;
    assign pc_out = pc_q;
    assign bit_flag = bit_flag_q;

    // ********************************************************
    // checks
    // ********************************************************
    a_short_load_nibble: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && op_code == oag_pkg::OAG_OP_LD_PTR0_SHORT |=>
        ptr0_q == {4'h0, $past(op_byte[3:0])})
        else $error("short pointer load wrong");
    a_step_after_use: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && is_ind && !ptr_sel && ptr_step == oag_pkg::OAG_STEP_INC |->
        dmem_addr == ptr0_q ##1 ptr0_q == $past(dmem_addr) + 8'h01)
        else $error("pointer post increment wrong");
    a_step_dec_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && is_ind && ptr_sel && ptr_step == oag_pkg::OAG_STEP_DEC &&
        ptr1_q == 8'h00 |=> ptr1_q == 8'hFF)
        else $error("pointer decrement did not wrap");
    a_direct_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && op_code == oag_pkg::OAG_OP_LD_DIR |-> dmem_addr == op_byte && dmem_rd)
        else $error("direct address wrong");
    a_table_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && op_code == oag_pkg::OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE |=>
        pmem_addr == {$past(pc_q[14:8]), $past(acc_q)})
        else $error("table address wrong");
    a_table_pc_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && op_code == oag_pkg::OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE |=> ##1 pc_q == $past(pc_q, 2) + 15'h0001)
        else $error("pc not advanced after table read");
    a_table_acc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == oag_pkg::OAG_ST_TABLE |=> acc_q == $past(pmem_rdata))
        else $error("table byte not loaded");
    a_bit_two_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && op_code == oag_pkg::OAG_OP_BIT_SET |=> !op_ready && dmem_wr &&
        dmem_addr == $past(op_byte) ##1 op_ready)
        else $error("bit set sequence wrong");
    a_single_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        take && op_code == oag_pkg::OAG_OP_LD_DIR |=> op_ready)
        else $error("single cycle op stalled");
endmodule
`default_nettype wire

// ### verilog/oag_defs.svh
// constants for the operand address generation block
// assumes inclusion by the design modules
//
// Contract
// - direct mode address is instruction byte
// - indirect uses first or second pointer
// - access at old pointer, then step
// - post step offered on load, exchange
// - immediate operand is next program byte
// - short load writes nibble into pointer
// - short load clears pointer high nibble
// - table read address from pc bytes
// - accumulator replaces pc low byte
// - table byte to accumulator, pc restored
// - set, clear, test any data bit
// - three pointers: two indirect, one stack
// - most single-byte ops take one cycle
// - program counter is fifteen bits wide
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
`define OAG_DW 8
`define OAG_PCW 15
`define OAG_NIB_W 4
`define OAG_HI_ZERO 4'h0
`define OAG_PTR_RST 8'h00
`define OAG_ACC_RST 8'h00
`define OAG_PC_RST 15'h0000
`define OAG_PC_STEP 15'h0001
`define OAG_PTR_STEP 8'h01
`define OAG_ADDR_PTR0 8'hFE
`define OAG_ADDR_PTR1 8'hFC
`define OAG_ADDR_SP 8'hFD
`endif

// ### verilog/oag_pkg.sv
// types for the operand address generation block
// assumes nothing beyond the defines header
package oag_pkg;
    typedef enum logic [3:0] {
        OAG_OP_NOP,
        OAG_OP_LD_DIR,
        OAG_OP_LD_IND,
        OAG_OP_X_IND,
        OAG_OP_ST_DIR,
        OAG_OP_LD_IMM,
        OAG_OP_LD_PTR0_SHORT,
        OAG_OP_LOAD_ACC_FROM_PROGRAM_TABLE,
        OAG_OP_BIT_SET,
        OAG_OP_BIT_CLR,
        OAG_OP_BIT_TEST
    } oag_op_t;
    typedef enum logic [1:0] {
        OAG_STEP_NONE,
        OAG_STEP_INC,
        OAG_STEP_DEC
    } oag_step_t;
    typedef enum logic [1:0] {
        OAG_ST_IDLE,
        OAG_ST_RMW,
        OAG_ST_TABLE
    } oag_state_t;
endpackage

// ### verilog/oag_ptr_step.sv
// pointer post-step unit
// assumes a synchronous caller that samples ptr_out as the next value
`include "oag_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module oag_ptr_step #(
    parameter int W = `OAG_DW
) (
    input wire logic [W-1:0] ptr_in,
    input wire oag_pkg::oag_step_t step,
    output logic [W-1:0] ptr_out
);
    // plain W-bit arithmetic drops the carry, giving the wrap
    always_comb begin
        case (step)
            oag_pkg::OAG_STEP_INC: ptr_out = ptr_in + W'(`OAG_PTR_STEP);
            oag_pkg::OAG_STEP_DEC: ptr_out = ptr_in - W'(`OAG_PTR_STEP);
            default: ptr_out = ptr_in;
        endcase
    end
endmodule
`default_nettype wire
